// file: hdl/flt_cfg.svh
`ifndef FLT_CFG_SVH
`define FLT_CFG_SVH

// ==========================================
// Register map
`define FLT_ADDR_LIMIT_TWO    8'h52
`define FLT_ADDR_DUTY_TWO     8'h53
`define FLT_ADDR_UNLOCK       8'h4A
`define FLT_ADDR_TEMP_OFFSET  8'h4E

// ==========================================
// Reset values
`define FLT_RST_LIMIT_TWO     8'h7F
`define FLT_RST_DUTY_TWO      8'h3F

// ==========================================
// Field positions
`define FLT_UNLOCK_BIT        5
`define FLT_LIMIT_HALF_BIT    7
`define FLT_LIMIT_DEG_MSB     6
`define FLT_DUTY_EXT_MSB      7
`define FLT_DUTY_EXT_LSB      6
`define FLT_DUTY_BASE_MSB     5

// ==========================================
// Widths
`define FLT_REG_W             8

`endif

// file: hdl/flt_pkg.sv
package flt_pkg;

  // ==========================================
  // Register access from the management bus slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flt_reg_req_s;

  // ==========================================
  // Operating modes
  typedef struct packed {
    logic temp_hires;
    logic duty_hires;
    logic pwm_22k5_sel;
  } flt_mode_s;

  // ==========================================
  // Remote diode reading, sign already stripped
  typedef struct packed {
    logic [7:0] degrees;
    logic       half;
  } flt_temp_s;

endpackage : flt_pkg

// file: hdl/flt_entry_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "flt_cfg.svh"

module flt_entry_reg
  import flt_pkg::*;
#(
  parameter int                         WIDTH     = 8,
  parameter logic [`FLT_REG_W-1:0]      RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  // Stored value
  output var  logic [WIDTH-1:0] value
);

  if (WIDTH != `FLT_REG_W) begin : g_width_chk
    $error("flt_entry_reg: WIDTH must equal the register width");
  end

  typedef struct packed {
    logic [WIDTH-1:0] val;
  } flt_ereg_s;

  flt_ereg_s st_q;
  flt_ereg_s st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.val = wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.val <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.val;

endmodule : flt_entry_reg

`default_nettype wire

// file: hdl/flt_lut_entry_two.sv
`timescale 1ns/1ps
`default_nettype none
`include "flt_cfg.svh"

// Summary of operation
// - Low-res temperature mode: limit half bit reads back as zero.
// - High-res: half bit plus seven degree bits, 0 to 127.5 in halves.
// - Low-res: only seven degree bits, 0 to 127 in whole degrees.
// - Remote temperature above limit selects the paired duty value for PWM.
// - Compare uses nine reading bits in high-res, eight in low-res.
// - Limit is always positive; sign bit taken as zero.
// - Table offset register is added to the limit for higher thresholds.
// - Low-res duty mode: two extended duty bits read back as zero.
// - High-res duty at 22.5 kHz: extended bits join the six base bits as duty.
// - Extended duty bits act only when 22.5 kHz PWM is selected.
// - Low-res duty: only the six base bits form the PWM value.

module flt_lut_entry_two
  import flt_pkg::*;
#(
  parameter int REG_W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Register access
  input  wire flt_reg_req_s reg_req,
  output var  logic [7:0]   reg_rdata,
  output var  logic         reg_rvalid,
  // Shared table settings
  input  wire logic [7:0]   unlock_reg,
  input  wire logic [7:0]   temp_offset,
  input  wire flt_mode_s    mode,
  // Measurement
  input  wire flt_temp_s    remote_temp,
  // Duty select toward the PWM generator
  output var  logic         limit_exceeded,
  output var  logic [7:0]   duty_value
);

  // ==========================================
  // Parameter check
  if (REG_W != `FLT_REG_W) begin : g_width_chk
    $error("flt_lut_entry_two: REG_W must equal the register width");
  end

  // ==========================================
  // Helpers
  function automatic logic [7:0] read_mask(input logic [7:0] raw, input logic lowres,
                                           input logic [7:0] clear_bits);
    read_mask = lowres ? (raw & ~clear_bits) : raw;
  endfunction : read_mask

  function automatic logic [7:0] duty_eff(input logic [7:0] raw, input flt_mode_s m);
    // Extended bits only matter at the high PWM rate
    if (m.duty_hires && m.pwm_22k5_sel) begin
      duty_eff = raw;
    end else begin
      duty_eff = {2'b00, raw[`FLT_DUTY_BASE_MSB:0]};
    end
  endfunction : duty_eff

  localparam logic [7:0] LIMIT_LO_MASK = 8'h80;
  localparam logic [7:0] DUTY_LO_MASK  = 8'hC0;

  // ==========================================
  // Entry registers
  logic [7:0] limit_two;
  logic [7:0] duty_two;
  logic       wr_ok;
  logic       wr_limit;
  logic       wr_duty;

  assign wr_ok    = unlock_reg[`FLT_UNLOCK_BIT];
  assign wr_limit = reg_req.wr && wr_ok && (reg_req.addr == `FLT_ADDR_LIMIT_TWO);
  assign wr_duty  = reg_req.wr && wr_ok && (reg_req.addr == `FLT_ADDR_DUTY_TWO);

  flt_entry_reg #(
    .WIDTH     (REG_W),
    .RESET_VAL (`FLT_RST_LIMIT_TWO)
  ) u_limit (
    .clk    (clk),
    .resetn (resetn),
    .wr_en  (wr_limit),
    .wdata  (reg_req.wdata),
    .value  (limit_two)
  );

  flt_entry_reg #(
    .WIDTH     (REG_W),
    .RESET_VAL (`FLT_RST_DUTY_TWO)
  ) u_duty (
    .clk    (clk),
    .resetn (resetn),
    .wr_en  (wr_duty),
    .wdata  (reg_req.wdata),
    .value  (duty_two)
  );

  // ==========================================
  // Limit comparison
  // Limit in half degrees: seven degree bits then the half bit
  logic [9:0] lim_hr;
  logic [9:0] temp_hr;
  logic [8:0] lim_lr;
  logic [8:0] temp_lr;
  logic       cmp_hr;
  logic       cmp_lr;

  // Offset has no sign, so the limit can only move upward
  assign lim_hr  = {2'b00, limit_two[`FLT_LIMIT_DEG_MSB:0], limit_two[`FLT_LIMIT_HALF_BIT]}
                 + {1'b0, temp_offset, 1'b0};
  assign temp_hr = {1'b0, remote_temp.degrees, remote_temp.half};
  assign lim_lr  = {2'b00, limit_two[`FLT_LIMIT_DEG_MSB:0]} + {1'b0, temp_offset};
  assign temp_lr = {1'b0, remote_temp.degrees};
  assign cmp_hr  = temp_hr > lim_hr;
  assign cmp_lr  = temp_lr > lim_lr;

  // ==========================================
  // State
  typedef struct packed {
    logic       above;
    logic [7:0] duty;
    logic [7:0] rdata;
    logic       rvalid;
  } flt_state_s;

  flt_state_s st_q;
  flt_state_s st_d;

  always_comb begin
    st_d        = st_q;
    st_d.above  = mode.temp_hires ? cmp_hr : cmp_lr;
    st_d.duty   = duty_eff(duty_two, mode);
    st_d.rvalid = 1'b0;
    st_d.rdata  = 8'h00;
    // Reads ignore the unlock; only this entry's two offsets answer
    if (reg_req.rd) begin
      case (reg_req.addr)
        `FLT_ADDR_LIMIT_TWO: begin
          st_d.rdata  = read_mask(limit_two, !mode.temp_hires, LIMIT_LO_MASK);
          st_d.rvalid = 1'b1;
        end
        `FLT_ADDR_DUTY_TWO: begin
          st_d.rdata  = read_mask(duty_two, !mode.duty_hires, DUTY_LO_MASK);
          st_d.rvalid = 1'b1;
        end
        default: begin
          st_d.rvalid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign limit_exceeded = st_q.above;
  assign duty_value     = st_q.duty;
  assign reg_rdata      = st_q.rdata;
  assign reg_rvalid     = st_q.rvalid;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Sampled reset in each antecedent: on the release edge the flops still sit in reset
  sequence s_rd_limit;
    resetn && reg_req.rd && reg_req.addr == `FLT_ADDR_LIMIT_TWO;
  endsequence

  sequence s_rd_duty;
    resetn && reg_req.rd && reg_req.addr == `FLT_ADDR_DUTY_TWO;
  endsequence

  sequence s_rd_other;
    resetn && reg_req.rd && reg_req.addr != `FLT_ADDR_LIMIT_TWO && reg_req.addr != `FLT_ADDR_DUTY_TWO;
  endsequence

  sequence s_locked_wr;
    resetn && reg_req.wr && !unlock_reg[`FLT_UNLOCK_BIT]
      && (reg_req.addr == `FLT_ADDR_LIMIT_TWO || reg_req.addr == `FLT_ADDR_DUTY_TWO);
  endsequence

  sequence s_open_wr_limit;
    resetn && reg_req.wr && unlock_reg[`FLT_UNLOCK_BIT] && reg_req.addr == `FLT_ADDR_LIMIT_TWO;
  endsequence

  sequence s_open_wr_duty;
    resetn && reg_req.wr && unlock_reg[`FLT_UNLOCK_BIT] && reg_req.addr == `FLT_ADDR_DUTY_TWO;
  endsequence

  sequence s_full_duty;
    resetn && mode.duty_hires && mode.pwm_22k5_sel;
  endsequence

  sequence s_part_duty;
    resetn && !(mode.duty_hires && mode.pwm_22k5_sel);
  endsequence

  // Reading exactly on the threshold: strict compare keeps the flag low
  sequence s_hr_on_limit;
    resetn && mode.temp_hires && temp_hr == lim_hr;
  endsequence

  sequence s_hr_half_above;
    resetn && mode.temp_hires && temp_hr == lim_hr + 10'd1;
  endsequence

  sequence s_lr_on_limit;
    resetn && !mode.temp_hires && {1'b0, remote_temp.degrees} == lim_lr;
  endsequence

  sequence s_lr_deg_above;
    resetn && !mode.temp_hires && {1'b0, remote_temp.degrees} == lim_lr + 9'd1;
  endsequence

  // ==========================================
  // Register read and write checks
  lo_limit_read_a: assert property (s_rd_limit ##0 !mode.temp_hires |=> reg_rvalid && !reg_rdata[7])
    else $error("limit half bit visible in low-res mode");

  hi_limit_read_a: assert property (s_rd_limit ##0 mode.temp_hires |=> reg_rdata == $past(limit_two))
    else $error("high-res limit read not whole");

  degree_read_a: assert property (s_rd_limit
    |=> reg_rvalid && reg_rdata[6:0] == $past(limit_two[6:0]))
    else $error("limit degree bits read wrong");

  lo_duty_read_a: assert property (s_rd_duty ##0 !mode.duty_hires
    |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
    else $error("extended duty bits visible in low-res mode");

  hi_duty_read_a: assert property (s_rd_duty ##0 mode.duty_hires |=> reg_rdata == $past(duty_two))
    else $error("high-res duty read not whole");

  base_read_a: assert property (s_rd_duty |=> reg_rvalid && reg_rdata[5:0] == $past(duty_two[5:0]))
    else $error("duty base bits read wrong");

  other_read_a: assert property (s_rd_other |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("foreign address answered");

  idle_read_a: assert property (resetn && !reg_req.rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer without a read");

  limit_write_a: assert property (s_open_wr_limit |=> limit_two == $past(reg_req.wdata))
    else $error("unlocked limit write lost");

  duty_write_a: assert property (s_open_wr_duty |=> duty_two == $past(reg_req.wdata))
    else $error("unlocked duty write lost");

  write_lock_a: assert property (s_locked_wr |=> $stable(limit_two) && $stable(duty_two))
    else $error("locked write changed an entry register");

  // ==========================================
  // Compare and duty checks
  hi_limit_cmp_a: assert property (resetn && mode.temp_hires |=> limit_exceeded == $past(cmp_hr))
    else $error("high-res compare mismatch");

  lo_limit_cmp_a: assert property (resetn && !mode.temp_hires |=> limit_exceeded == $past(cmp_lr))
    else $error("low-res compare mismatch");

  on_limit_a: assert property (s_hr_on_limit |=> !limit_exceeded)
    else $error("reading equal to limit counted as exceeding");

  half_step_a: assert property (s_hr_half_above |=> limit_exceeded)
    else $error("half degree above limit not flagged");

  deg_step_a: assert property (s_lr_deg_above |=> limit_exceeded)
    else $error("one degree above limit not flagged");

  duty_select_a: assert property ($rose(limit_exceeded)
    |-> duty_value == ($past(mode.duty_hires && mode.pwm_22k5_sel)
                       ? $past(duty_two) : {2'b00, $past(duty_two[5:0])}))
    else $error("duty value not paired with exceeded limit");

  lo_half_ignored_a: assert property (s_lr_on_limit |=> !limit_exceeded)
    else $error("low-res compare used the half bit");

  offset_floor_a: assert property (!mode.temp_hires && temp_lr <= {1'b0, temp_offset}
    |=> !limit_exceeded)
    else $error("temperature below offset flagged above limit");

  hi_duty_a: assert property (s_full_duty |=> duty_value == $past(duty_two))
    else $error("high-res duty not taken whole");

  ext_gated_a: assert property (s_part_duty
    |=> duty_value[7:6] == 2'b00 ##0 duty_value[5:0] == $past(duty_two[5:0]))
    else $error("extended duty bits acted outside 22.5 kHz high-res");

endmodule : flt_lut_entry_two

`default_nettype wire

// file: tb/tb_flt_lut_entry_two.sv
`timescale 1ns/1ps
`default_nettype none

module tb_flt_lut_entry_two
  import flt_pkg::*;
  ;
  // ==========================================
  // Stimulus and observed signals
  logic         clk    = 1'b0;
  logic         resetn = 1'b0;
  flt_reg_req_s req    = '0;
  logic [7:0]   unl    = 8'h00;
  logic [7:0]   off    = 8'h00;
  flt_mode_s    mode   = '0;
  flt_temp_s    tmp    = '0;
  logic [7:0]   rdata;
  logic [7:0]   duty;
  logic         rvalid;
  logic         exc;
  logic [7:0]   lim_m  = 8'h7F;
  logic [7:0]   duty_m = 8'h3F;
  logic [7:0]   a;
  int           err_total = 0;
  int           checks    = 0;
  int           cyc       = 0;
  int           seed      = 68;

  always #20 clk = ~clk;

  flt_lut_entry_two u_dut (
    .clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .unlock_reg(unl), .temp_offset(off), .mode(mode), .remote_temp(tmp),
    .limit_exceeded(exc), .duty_value(duty)
  );

  // ==========================================
  // Reporting
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Roughly 1900 cycles expected; generous ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // ==========================================
  // Expectations
  function automatic logic [7:0] rd_exp(input logic [7:0] ad);
    if (ad == 8'h52) return mode.temp_hires ? lim_m : {1'b0, lim_m[6:0]};
    if (ad == 8'h53) return mode.duty_hires ? duty_m : {2'b00, duty_m[5:0]};
    return 8'h00;
  endfunction : rd_exp

  // Widened sums so a large offset never wraps
  function automatic logic exp_exc(input flt_temp_s t, input logic [7:0] o, input logic hi);
    if (hi) return {1'b0, t.degrees, t.half} > ({2'b00, lim_m[6:0], lim_m[7]} + {1'b0, o, 1'b0});
    return {1'b0, t.degrees} > ({2'b00, lim_m[6:0]} + {1'b0, o});
  endfunction : exp_exc

  // ==========================================
  // Bus and compare tasks
  task automatic rd_chk(input logic [7:0] ad);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= ad;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("rvalid", {7'h00, ad == 8'h52 || ad == 8'h53}, {7'h00, rvalid});
    chk("rdata", rd_exp(ad), rdata);
  endtask : rd_chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= ad;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    if (unl[5] && ad == 8'h52) lim_m = d;
    if (unl[5] && ad == 8'h53) duty_m = d;
  endtask : wr

  // Corner case sits on the threshold or one step above it; strict compare decides
  task automatic step(input bit eq, input flt_mode_s m);
    flt_temp_s  t;
    logic [7:0] o;
    @(posedge clk);
    t = 9'($random(seed));
    o = 8'($random(seed));
    if (eq) begin
      o = {1'b0, o[6:0]};
      if (m.temp_hires) t = 9'({2'b00, lim_m[6:0], lim_m[7]} + {1'b0, o, 1'b0} + 10'(o[0]));
      else t.degrees = {1'b0, lim_m[6:0]} + o + 8'(o[0]);
    end
    mode <= m;
    off  <= o;
    tmp  <= t;
    unl  <= 8'($random(seed));
    @(posedge clk);
    #1;
    chk("limit_exceeded", {7'h00, exp_exc(t, o, m.temp_hires)}, {7'h00, exc});
    chk("duty_value", (m.duty_hires & m.pwm_22k5_sel) ? duty_m : {2'b00, duty_m[5:0]}, duty);
  endtask : step

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(8'h52);
    rd_chk(8'h53);
    rd_chk(8'h54);
    wr(8'h52, 8'h15);
    rd_chk(8'h52);
    unl <= 8'h20;
    wr(8'h52, 8'hFF);
    wr(8'h53, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      mode <= 3'(i);
      rd_chk(8'h52);
      rd_chk(8'h53);
      step(i[3], 3'(i));
    end
    repeat (300) begin
      a = 8'h51 + 8'(2'($random(seed)));
      wr(a, 8'($random(seed)));
      rd_chk(a);
      step(($random(seed) & 3) == 0, 3'($random(seed)));
    end
    // Mid-run reset brings both entries back to their defaults
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    lim_m  = 8'h7F;
    duty_m = 8'h3F;
    rd_chk(8'h52);
    rd_chk(8'h53);
    step(1'b1, 3'b111);
    print_verdict();
  end

endmodule : tb_flt_lut_entry_two

`default_nettype wire
